// ### logic/cc_status_pkg.sv
// Constants shared by the configuration-channel and supply status report logic.
// Assumes a single 100 MHz clock and an asynchronous active-high reset.

package cc_status_pkg;

	// *****************************************************************
	// Register map
	// *****************************************************************
	localparam logic [7:0] PIN_STATE_OFFSET = 8'h1d;
	localparam logic [7:0] SUPPLY_OFFSET    = 8'h1e;

	localparam logic [7:0] PIN_STATE_RESET  = 8'h00;
	localparam logic [7:0] SUPPLY_RESET     = 8'h08;
	localparam logic [7:0] UNMAPPED_VALUE   = 8'h00;

	// *****************************************************************
	// Pin-state register fields
	// *****************************************************************
	localparam int FIRST_PIN_LSB   = 0;
	localparam int SECOND_PIN_LSB  = 2;
	localparam int ATTACH_BIT      = 4;
	localparam int SEEKING_BIT     = 5;

	localparam logic [1:0] PIN_OPEN     = 2'h0;
	localparam logic [1:0] PIN_RA       = 2'h1;
	localparam logic [1:0] PIN_RD       = 2'h2;
	localparam logic [1:0] PIN_RESERVED = 2'h3;

	// Role-control field value that selects open termination.
	localparam logic [1:0] ROLE_OPEN    = 2'h3;

	// *****************************************************************
	// Supply register fields
	// *****************************************************************
	localparam int SINK_BIT        = 0;
	localparam int CABLE_PWR_BIT   = 1;
	localparam int BUS_PRESENT_BIT = 2;
	localparam int DETECT_EN_BIT   = 3;
	localparam int SOURCING_BIT    = 4;
	localparam int NONDEFAULT_BIT  = 5;
	localparam int INIT_BIT        = 6;
	localparam int DEBUG_ACC_BIT   = 7;

	// *****************************************************************
	// Timing
	// *****************************************************************
	localparam int CLOCK_PERIOD_NS          = 10;
	localparam int PIN_DEBOUNCE_TIME_NS     = 375000;
	localparam int STATUS_UPDATE_LIMIT_NS   = 50000;
	localparam int PIN_DEBOUNCE_CYCLES      = PIN_DEBOUNCE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int STATUS_UPDATE_LIMIT_CYC  = STATUS_UPDATE_LIMIT_NS / CLOCK_PERIOD_NS;
	localparam int DEBOUNCE_COUNT_WIDTH     = 20;

	localparam logic [DEBOUNCE_COUNT_WIDTH-1:0] COUNT_ZERO = 20'h0_0000;
	localparam logic [DEBOUNCE_COUNT_WIDTH-1:0] COUNT_ONE  = 20'h0_0001;

endpackage : cc_status_pkg

// ### logic/cc_filter_if.sv
// Carries raw and debounced pin codes between the status block and its filter.
// Assumes both ends share the same clock.
`timescale 1ns/100ps
`default_nettype none

interface cc_filter_if;
	logic [1:0] first_raw;      // Synchronised first pin code
	logic [1:0] second_raw;     // Synchronised second pin code
	logic [1:0] first_stable;   // Debounced first pin code
	logic [1:0] second_stable;  // Debounced second pin code

	modport filter (
		input  first_raw,
		input  second_raw,
		output first_stable,
		output second_stable
	);

	modport owner (
		output first_raw,
		output second_raw,
		input  first_stable,
		input  second_stable
	);
endinterface : cc_filter_if

`default_nettype wire

// ### logic/cc_pin_filter.sv
// Debounce filter for the two configuration-channel pin codes.
// Assumes its inputs are already synchronised to clock.
`timescale 1ns/100ps
`default_nettype none

module cc_pin_filter #(
	parameter int DEBOUNCE_CYCLES = cc_status_pkg::PIN_DEBOUNCE_CYCLES
) (
	input  wire logic   clock,  // System clock
	input  wire logic   rst,    // Asynchronous reset, active high
	cc_filter_if.filter pins    // Raw codes in, debounced codes out
);

	localparam logic [cc_status_pkg::DEBOUNCE_COUNT_WIDTH-1:0] LAST_COUNT =
		cc_status_pkg::DEBOUNCE_COUNT_WIDTH'(DEBOUNCE_CYCLES - 1);

	logic [1:0]                                    first_cand_reg;
	logic [1:0]                                    second_cand_reg;
	logic [cc_status_pkg::DEBOUNCE_COUNT_WIDTH-1:0] first_count_reg;
	logic [cc_status_pkg::DEBOUNCE_COUNT_WIDTH-1:0] second_count_reg;
	logic [1:0]                                    first_stable_reg;
	logic [1:0]                                    second_stable_reg;

	// *****************************************************************
	// Debounce
	// *****************************************************************
	// A code is accepted only after it held unchanged for the whole
	// debounce time; any glitch restarts the wait from zero.
	// Debounce first pin
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			first_cand_reg   <= cc_status_pkg::PIN_OPEN;
			first_count_reg  <= cc_status_pkg::COUNT_ZERO;
			first_stable_reg <= cc_status_pkg::PIN_OPEN;
		end
		else if (pins.first_raw != first_cand_reg)
		begin
			first_cand_reg  <= pins.first_raw;
			first_count_reg <= cc_status_pkg::COUNT_ZERO;
		end
		else if (first_count_reg < LAST_COUNT)
			first_count_reg <= first_count_reg + cc_status_pkg::COUNT_ONE;
		else
			first_stable_reg <= first_cand_reg;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			second_cand_reg   <= cc_status_pkg::PIN_OPEN;
			second_count_reg  <= cc_status_pkg::COUNT_ZERO;
			second_stable_reg <= cc_status_pkg::PIN_OPEN;
		end
		else if (pins.second_raw != second_cand_reg)
		begin
			second_cand_reg  <= pins.second_raw;
			second_count_reg <= cc_status_pkg::COUNT_ZERO;
		end
		else if (second_count_reg < LAST_COUNT)
			second_count_reg <= second_count_reg + cc_status_pkg::COUNT_ONE;
		else
			second_stable_reg <= second_cand_reg;
	end

	assign pins.first_stable  = first_stable_reg;
	assign pins.second_stable = second_stable_reg;

endmodule : cc_pin_filter

`default_nettype wire

// ### logic/cc_power_status_reporting.sv
// Pin-state and supply status report registers of the port controller.
// Assumes pin codes and gate drive arrive asynchronously, all other
// status inputs come from logic on clock, and a register front end
// issues one-cycle read strobes with an address.
`timescale 1ns/100ps
`default_nettype none

module cc_power_status_reporting #(
	parameter int DEBOUNCE_CYCLES = cc_status_pkg::PIN_DEBOUNCE_CYCLES  // Debounce length in cycles
) (
	input  wire logic       clock,                     // System clock, 100 MHz
	input  wire logic       rst,                       // Asynchronous reset, active high
	input  wire logic [1:0] first_config_pin,          // First pin comparator code, async
	input  wire logic [1:0] second_config_pin,         // Second pin comparator code, async
	input  wire logic       shield_gate_drive,         // Shield gate drive level, async
	input  wire logic [1:0] first_role,                // Role-control field for first pin
	input  wire logic [1:0] second_role,               // Role-control field for second pin
	input  wire logic       seeking_attach,            // Attach search in progress
	input  wire logic       debug_accessory,           // Debug accessory attached
	input  wire logic       init_busy,                 // Internal initialisation running
	input  wire logic       nondefault_source,         // Sourcing non-default bus voltage
	input  wire logic       sourcing,                  // Sourcing bus voltage
	input  wire logic       bus_detect_enabled,        // Bus detection comparators enabled
	input  wire logic       bus_present,               // Bus voltage present
	input  wire logic       cable_power_present,       // Cable power present
	input  wire logic       sinking,                   // Sinking bus voltage
	input  wire logic       reg_rd,                    // Read strobe, one cycle
	input  wire logic [7:0] reg_addr,                  // Read address
	output logic      [7:0] reg_rdata,                 // Read data, registered
	output logic            reg_rvalid,                // Read data valid, one cycle
	output logic      [7:0] cable_pin_state_report,    // Live pin-state register
	output logic      [7:0] supply_state_report,       // Live supply register
	output logic            pin_state_alert_bit,       // Pin-state change event, one cycle
	output logic            supply_alert_bit           // Supply change event, one cycle
);

	cc_filter_if filt ();

	logic [1:0] first_meta_reg;
	logic [1:0] first_sync_reg;
	logic [1:0] second_meta_reg;
	logic [1:0] second_sync_reg;
	logic       gate_meta_reg;
	logic       gate_sync_reg;

	logic       reporting_off;
	logic       reporting_off_reg;
	logic [1:0] first_shown;
	logic [1:0] second_shown;
	logic [7:0] pin_state_next;
	logic [7:0] pin_state_reg;
	logic [7:0] supply_next;
	logic [7:0] supply_reg;
	logic       pin_event_reg;
	logic       supply_event_reg;
	logic [7:0] rdata_reg;
	logic       rvalid_reg;

	// *****************************************************************
	// Functions
	// *****************************************************************
	// Without gate drive the cable ground may float, so only Open is
	// trusted; the reserved code is never passed through either.
	function automatic logic [1:0] qualify_code(input logic [1:0] code, input logic gate);
		logic [1:0] shown;
		shown = cc_status_pkg::PIN_OPEN;
		if (gate && (code == cc_status_pkg::PIN_RA || code == cc_status_pkg::PIN_RD))
			shown = code;
		return shown;
	endfunction : qualify_code

	function automatic logic is_ra_open(input logic [1:0] a, input logic [1:0] b);
		return (a == cc_status_pkg::PIN_RA) && (b == cc_status_pkg::PIN_OPEN);
	endfunction : is_ra_open

	// *****************************************************************
	// Input synchronisers
	// *****************************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			first_meta_reg  <= cc_status_pkg::PIN_OPEN;
			first_sync_reg  <= cc_status_pkg::PIN_OPEN;
			second_meta_reg <= cc_status_pkg::PIN_OPEN;
			second_sync_reg <= cc_status_pkg::PIN_OPEN;
			gate_meta_reg   <= 1'b0;
			gate_sync_reg   <= 1'b0;
		end
		else
		begin
			first_meta_reg  <= first_config_pin;
			first_sync_reg  <= first_meta_reg;
			second_meta_reg <= second_config_pin;
			second_sync_reg <= second_meta_reg;
			gate_meta_reg   <= shield_gate_drive;
			gate_sync_reg   <= gate_meta_reg;
		end
	end

	assign filt.first_raw  = first_sync_reg;
	assign filt.second_raw = second_sync_reg;

	cc_pin_filter #(
		.DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
	) u_filter (
		.clock (clock),
		.rst   (rst),
		.pins  (filt)
	);

	// *****************************************************************
	// Pin-state register
	// *****************************************************************
	// Open roles disable
	assign reporting_off = (first_role == cc_status_pkg::ROLE_OPEN) &&
	                       (second_role == cc_status_pkg::ROLE_OPEN);

	always_comb
	begin
		first_shown  = qualify_code(filt.first_stable, gate_sync_reg);
		second_shown = qualify_code(filt.second_stable, gate_sync_reg);
		if (seeking_attach &&
		    (is_ra_open(first_shown, second_shown) || is_ra_open(second_shown, first_shown)))
		begin
			first_shown  = cc_status_pkg::PIN_OPEN;
			second_shown = cc_status_pkg::PIN_OPEN;
		end
		pin_state_next = 8'h00;
		pin_state_next[cc_status_pkg::FIRST_PIN_LSB +: 2]  = first_shown;
		pin_state_next[cc_status_pkg::SECOND_PIN_LSB +: 2] = second_shown;
		pin_state_next[cc_status_pkg::ATTACH_BIT] = 1'b0;
		pin_state_next[cc_status_pkg::SEEKING_BIT] = seeking_attach;
		if (reporting_off)
			pin_state_next = 8'h00;
	end

	// The register follows its inputs one cycle after the debounced code
	// settles, far inside the allowed update time.
	// Prompt register update
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pin_state_reg <= cc_status_pkg::PIN_STATE_RESET;
		else
			pin_state_reg <= pin_state_next;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			reporting_off_reg <= 1'b0;
		else
			reporting_off_reg <= reporting_off;
	end

	// Changes caused by entering or leaving the disabled state are not
	// reported; only a change seen while reporting stays enabled is.
	// No event on disable
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pin_event_reg <= 1'b0;
		else
			pin_event_reg <= (pin_state_next != pin_state_reg) && !reporting_off && !reporting_off_reg;
	end

	// *****************************************************************
	// Supply register
	// *****************************************************************
	always_comb
	begin
		supply_next = 8'h00;
		supply_next[cc_status_pkg::DEBUG_ACC_BIT]   = debug_accessory;
		supply_next[cc_status_pkg::INIT_BIT]        = init_busy;
		supply_next[cc_status_pkg::NONDEFAULT_BIT]  = nondefault_source;
		supply_next[cc_status_pkg::SOURCING_BIT]    = sourcing;
		supply_next[cc_status_pkg::DETECT_EN_BIT]   = bus_detect_enabled;
		supply_next[cc_status_pkg::BUS_PRESENT_BIT] = bus_present;
		supply_next[cc_status_pkg::CABLE_PWR_BIT]   = cable_power_present;
		supply_next[cc_status_pkg::SINK_BIT]        = sinking;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			supply_reg <= cc_status_pkg::SUPPLY_RESET;
		else
			supply_reg <= supply_next;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			supply_event_reg <= 1'b0;
		else
			supply_event_reg <= (supply_next != supply_reg);
	end

	// *****************************************************************
	// Register read port
	// *****************************************************************
	// There is no write path at all, so nothing outside can alter
	// either register; unmapped addresses read as zero.
	// Read-only access
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rdata_reg  <= cc_status_pkg::UNMAPPED_VALUE;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rvalid_reg <= reg_rd;
			if (reg_rd)
			begin
				unique case (reg_addr)
					cc_status_pkg::PIN_STATE_OFFSET: rdata_reg <= pin_state_reg;
					cc_status_pkg::SUPPLY_OFFSET:    rdata_reg <= supply_reg;
					default:                         rdata_reg <= cc_status_pkg::UNMAPPED_VALUE;
				endcase
			end
		end
	end

	assign reg_rdata              = rdata_reg;
	assign reg_rvalid             = rvalid_reg;
	assign cable_pin_state_report = pin_state_reg;
	assign supply_state_report    = supply_reg;
	assign pin_state_alert_bit    = pin_event_reg;
	assign supply_alert_bit       = supply_event_reg;

endmodule : cc_power_status_reporting

`default_nettype wire

// ### tb/cc_status_props.sv
// Assertions on the ports of the status report block.
// Bound from the testbench top; one clock, reset active high.
`timescale 1ns/100ps
`default_nettype none

module cc_status_props (
	input wire logic       clock, rst, shield_gate_drive, seeking_attach, debug_accessory,
	input wire logic       init_busy, nondefault_source, sourcing, bus_detect_enabled, bus_present,
	input wire logic       cable_power_present, sinking, reg_rd, reg_rvalid, pin_state_alert_bit,
	input wire logic       supply_alert_bit,
	input wire logic [1:0] first_config_pin, second_config_pin, first_role, second_role,
	input wire logic [7:0] reg_addr, reg_rdata, cable_pin_state_report, supply_state_report
);
	logic       off;
	logic [7:0] sup_in;

	assign off = (first_role == 2'h3) && (second_role == 2'h3);
	assign sup_in = {debug_accessory, init_busy, nondefault_source, sourcing,
		bus_detect_enabled, bus_present, cable_power_present, sinking};

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Two disabled samples put the first check one cycle after the slot where an entry alert would land.
	sequence s_off2;
		off [*2];
	endsequence

	a_attach_zero: assert property (cable_pin_state_report[4] == 1'b0)
		else $error("attach result bit set");
	a_spare_zero: assert property (cable_pin_state_report[7:6] == 2'h0)
		else $error("spare pin-state bits set");
	a_off_zero: assert property (off |=> cable_pin_state_report == 8'h00)
		else $error("pin-state not zero while disabled");
	a_off_quiet: assert property (s_off2 |=> !pin_state_alert_bit)
		else $error("alert raised by disabling");
	a_seek_bit: assert property (!off |=> cable_pin_state_report[5] == $past(seeking_attach))
		else $error("seeking bit wrong");
	a_gate_low: assert property (!shield_gate_drive [*6] |-> cable_pin_state_report[3:0] == 4'h0)
		else $error("pin code shown with gate low");
	a_supply_map: assert property (1'b1 |=> supply_state_report == $past(sup_in))
		else $error("supply register does not follow inputs");
	a_supply_alert: assert property ($changed(supply_state_report) |-> ##[0:1] supply_alert_bit)
		else $error("supply change without alert");
	a_read_valid: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after strobe");
	a_read_data: assert property (reg_rd && reg_addr == 8'h1e |=> reg_rdata == $past(supply_state_report))
		else $error("supply read data wrong");
endmodule : cc_status_props

`default_nettype wire

// ### tb/port_manager_model.sv
// Port manager model: reads status registers after alerts or on request.
// Assumes the block answers a read strobe one cycle later.
`timescale 1ns/100ps
`default_nettype none

module port_manager_model (
	input  wire logic       clock,               // System clock
	input  wire logic       rst,                 // Reset, active high
	input  wire logic       pin_state_alert_bit, // Pin-state alert event
	input  wire logic       supply_alert_bit,    // Supply alert event
	input  wire logic       req,                 // Bench read request
	input  wire logic [7:0] req_addr,            // Bench read address
	output logic            reg_rd,              // Read strobe
	output logic      [7:0] reg_addr,            // Read address
	input  wire logic [7:0] reg_rdata,           // Read data
	input  wire logic       reg_rvalid,          // Read data valid
	output logic      [7:0] last_pin,            // Last pin-state read
	output logic      [7:0] last_supply,         // Last supply read
	output logic      [7:0] last_data            // Last read of any kind
);
	logic pin_due;
	logic sup_due;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			{pin_due, sup_due, reg_rd} <= 3'h0;
			{reg_addr, last_pin, last_supply, last_data} <= 32'h0000_0000;
		end
		else
		begin
			reg_rd <= 1'b0;
			if (reg_rvalid)
			begin
				last_data <= reg_rdata;
				if (reg_addr == 8'h1d)
					last_pin <= reg_rdata;
				if (reg_addr == 8'h1e)
					last_supply <= reg_rdata;
			end
			// Alert reads wait until the answer is taken, so only one of them is in flight; a bench request is issued at once.
			if (req)
				{reg_rd, reg_addr} <= {1'b1, req_addr};
			else if (!reg_rd && !reg_rvalid && pin_due)
				{reg_rd, reg_addr, pin_due} <= {1'b1, 8'h1d, 1'b0};
			else if (!reg_rd && !reg_rvalid && sup_due)
				{reg_rd, reg_addr, sup_due} <= {1'b1, 8'h1e, 1'b0};
			if (pin_state_alert_bit)
				pin_due <= 1'b1;
			if (supply_alert_bit)
				sup_due <= 1'b1;
		end
	end
endmodule : port_manager_model

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the status report block.
// Drives the block and the port manager model from one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic       clock, rst, shield_gate_drive, seeking_attach, req, reg_rd, reg_rvalid;
	logic       pin_state_alert_bit, supply_alert_bit;
	logic [1:0] first_config_pin, second_config_pin, first_role, second_role;
	logic [7:0] sup_drv, req_addr, reg_addr, reg_rdata, cable_pin_state_report;
	logic [7:0] supply_state_report, last_pin, last_supply, last_data;
	wire        debug_accessory, init_busy, nondefault_source, sourcing;
	wire        bus_detect_enabled, bus_present, cable_power_present, sinking;
	int         fails, compares;

	assign {debug_accessory, init_busy, nondefault_source, sourcing,
		bus_detect_enabled, bus_present, cable_power_present, sinking} = sup_drv;

	cc_power_status_reporting #(.DEBOUNCE_CYCLES(8)) i_dut (.*);
	port_manager_model i_pm (.*);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	// The bound of 60 cycles is far inside the update limit.
	task automatic wait_pin(input logic [7:0] exp);
		for (int i = 0; i < 60 && cable_pin_state_report !== exp; i++)
			tick(1);
		chk("pin state", cable_pin_state_report, exp);
	endtask : wait_pin

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		{req, req_addr} = {1'b1, a};
		tick(1);
		req = 1'b0;
		tick(3);
		chk("read data", last_data, exp);
	endtask : rd

	task automatic t_regs();
		rd(8'h1d, 8'h00);
		rd(8'h1e, 8'h08);
		rd(8'h1f, 8'h00);
	endtask : t_regs

	task automatic t_pins();
		logic [7:0] e [4] = '{8'h04, 8'h01, 8'h02, 8'h08};
		shield_gate_drive = 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			{first_config_pin, second_config_pin} = {c[1:0], c[1:0] ^ 2'h1};
			wait_pin(e[c]);
			tick(8);
			chk("manager pin", last_pin, e[c]);
		end
		first_config_pin = 2'h2;
		tick(3);
		first_config_pin = 2'h3;
		tick(30);
		chk("glitch", cable_pin_state_report, 8'h08);
	endtask : t_pins

	task automatic t_gate();
		{first_config_pin, second_config_pin} = 4'h9;
		wait_pin(8'h06);
		shield_gate_drive = 1'b0;
		wait_pin(8'h00);
		shield_gate_drive = 1'b1;
		wait_pin(8'h06);
	endtask : t_gate

	task automatic t_seek();
		seeking_attach = 1'b1;
		{first_config_pin, second_config_pin} = 4'h4;
		wait_pin(8'h20);
		{first_config_pin, second_config_pin} = 4'h1;
		// The value already stands, so let the new codes pass the debounce first.
		tick(20);
		wait_pin(8'h20);
		{first_config_pin, second_config_pin} = 4'h9;
		wait_pin(8'h26);
		seeking_attach = 1'b0;
		wait_pin(8'h06);
		{first_config_pin, second_config_pin} = 4'h4;
		wait_pin(8'h01);
	endtask : t_seek

	task automatic t_off();
		int n = 0;
		first_role = 2'h3;
		tick(4);
		chk("one field open", cable_pin_state_report, 8'h01);
		second_role = 2'h3;
		repeat (20)
		begin
			tick(1);
			n += pin_state_alert_bit;
		end
		chk("disabled", cable_pin_state_report, 8'h00);
		chk("disable alerts", 8'(n), 8'h00);
		first_config_pin = 2'h2;
		tick(20);
		chk("disabled change", cable_pin_state_report, 8'h00);
		{first_role, second_role} = 4'h0;
		wait_pin(8'h02);
	endtask : t_off

	task automatic t_supply();
		for (int i = 0; i < 8; i++)
		begin
			sup_drv = 8'h01 << i;
			tick(10);
			chk("supply", supply_state_report, 8'h01 << i);
			chk("manager supply", last_supply, 8'h01 << i);
		end
	endtask : t_supply

	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// The tests take about 350 cycles; this limit of 10000 cycles leaves a wide margin.
	initial
	begin
		#100000;
		fails++;
		test_done();
	end

	initial
	begin
		rst = 1'b1;
		{shield_gate_drive, seeking_attach, req} = 3'h0;
		{first_config_pin, second_config_pin, first_role, second_role} = 8'h00;
		sup_drv = 8'h08;
		req_addr = 8'h00;
		fails = 0;
		compares = 0;
		repeat (16) @(posedge clock);
		chk("pin reset", cable_pin_state_report, 8'h00);
		chk("supply reset", supply_state_report, 8'h08);
		#1 rst = 1'b0;
		tick(2);
		t_regs();
		t_pins();
		t_gate();
		t_seek();
		t_off();
		t_supply();
		test_done();
	end
endmodule : tb

bind cc_power_status_reporting cc_status_props i_props (.*);

`default_nettype wire
